// File: design/efap_pkg.sv
// constants and carrier types for the embedded flash access path
package efap_pkg;
    // array size: 32 x 64 KB plus 8 x 8 KB, in bytes
    localparam int unsigned ARRAY_BYTES   = 32 * 65536 + 8 * 8192;
    // cpu address windows
    localparam logic [31:0] CPU_BIG_LO    = 32'h0004_0000;
    localparam logic [31:0] CPU_BIG_HI    = 32'h0023_ffff;
    localparam logic [15:0] CPU_SMALL_SEG = 16'h0024;
    // security vector, sixteen bytes
    localparam logic [31:0] SEC_VEC_LO    = 32'h0024_8000;
    localparam logic [31:0] SEC_VEC_HI    = 32'h0024_800f;
    // programming-mode address windows
    localparam logic [5:0]  PRG_SMALL_SEG = 6'h1f;
    localparam int          PRG_BIG_BIT   = 21;
    localparam int          PRG_HIGH_BIT  = 22;
    // row index layout: small sectors sit above the big ones
    localparam logic [18:0] SMALL_ROW_BASE = 19'h4_0000;
    localparam logic [18:0] SEC_ROW        = 19'h4_1000;
    // mode pins pattern for parallel programming
    localparam logic [2:0]  PROG_PINS     = 3'b111;
    // boot routine entry that may switch the access mode
    localparam logic [15:0] MODE_SW_ENTRY = 16'hbf60;
    // access mode after reset
    localparam logic [1:0]  MODE_RESET    = 2'b01;
    // security vector word that locks the array; value is arbitrary
    localparam logic [31:0] SEC_KEY       = 32'h5a5a_0001;
    // wait-state field width
    localparam int          WS_W          = 4;

    typedef enum logic [1:0] {
        MODE_W64 = 2'b00,
        MODE_W32 = 2'b01,
        MODE_W16 = 2'b10
    } efap_mode_t;

    typedef enum logic [1:0] {
        SRC_BOOT = 2'b00,
        SRC_CPU  = 2'b01,
        SRC_PROG = 2'b10
    } efap_src_t;

    // one array access command
    typedef struct packed {
        logic        req;
        logic        we;
        logic [18:0] row;
        efap_mode_t  width;
        logic [1:0]  hw;
        logic [63:0] wdata;
    } efap_arr_t;

    // one decoded access
    typedef struct packed {
        logic        ok;
        logic [18:0] row;
        logic [1:0]  hw;
    } efap_dec_t;
endpackage : efap_pkg

// File: design/efap_top.sv
// flash access path between cpu bus, parallel programmer and the array
`timescale 1ns/10ps
module efap_top (
    input  wire logic                 CLK_SYS,          // 20 MHz system clock
    input  wire logic                 RST,              // async reset, high
    input  wire logic [2:0]           MODE_SELECT_PINS, // device mode pins
    input  wire logic [3:0]           WAIT_STATES,      // extra array cycles
    input  wire logic                 MODE_REQ,         // mode switch strobe
    input  wire logic [1:0]           MODE_REQ_SEL,     // requested mode
    input  wire logic [15:0]          MODE_REQ_PC,      // caller routine entry
    input  wire logic                 CPU_REQ,          // cpu access request
    input  wire logic                 CPU_WE,           // cpu write
    input  wire logic                 CPU_FETCH,        // instruction fetch
    input  wire logic [31:0]          CPU_ADDR,         // cpu byte address
    input  wire logic [31:0]          CPU_WDATA,        // cpu write data
    output logic                      CPU_READY,        // access done pulse
    output logic                      CPU_ERR,          // refused, with ready
    output logic [31:0]               CPU_RDATA,        // cpu read data
    input  wire logic [22:0]          PROGRAMMING_ADDRESS, // programmer address
    input  wire logic                 PROG_CE_N,        // programmer select
    input  wire logic                 PROG_WE_N,        // programmer write
    input  wire logic                 PROG_OE_N,        // programmer read
    input  wire logic [15:0]          PROG_DQ_I,        // data from programmer
    output logic [15:0]               PROG_DQ_O,        // data to programmer
    output logic                      PROG_DQ_OE_N,     // low while driving
    output logic                      PROG_MODE,        // programming mode on
    output logic                      SECURED,          // array locked
    output logic [1:0]                ACCESS_MODE,      // active access mode
    output efap_pkg::efap_arr_t       ARR_CMD,          // array command
    input  wire logic [63:0]          ARR_RDATA         // array read row
);

    typedef enum logic [1:0] {
        ST_BOOT   = 2'b00,
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10,
        ST_DONE   = 2'b11
    } efap_state_t;
    efap_state_t          state, next_state;
    efap_pkg::efap_src_t  src, next_src;
    efap_pkg::efap_mode_t mode, next_mode, pend_mode, next_pend_mode;
    logic                 pend, next_pend, we, next_we, err, next_err;
    logic [3:0]           wcnt, next_wcnt;
    logic [18:0]          row, next_row, lrow, next_lrow;
    logic [1:0]           hw, next_hw;
    logic [63:0]          wdata, next_wdata, lbuf, next_lbuf;
    logic [31:0]          rdata, next_rdata;
    logic [15:0]          pdata, next_pdata;
    logic                 secured, next_secured, lvalid, next_lvalid;
    logic                 ce_q, next_ce_q, pvalid, next_pvalid;
    efap_pkg::efap_dec_t  cdec, pdec;
    logic                 prog_mode, prog_start, cpu_align, cpu_refuse;
    logic [31:0]          coff;
    logic [15:0]          whalf;

    // all mode pins high select programming mode
    assign prog_mode  = (MODE_SELECT_PINS == efap_pkg::PROG_PINS);
    assign prog_start = prog_mode && ce_q && !PROG_CE_N && (!PROG_WE_N || !PROG_OE_N);
    // cpu address decode to array row and halfword lane
    always_comb begin
        coff = CPU_ADDR - efap_pkg::CPU_BIG_LO;
        cdec = '0;
        // big sectors paired, even in +0..+3, odd in +4..+7
        if (CPU_ADDR >= efap_pkg::CPU_BIG_LO && CPU_ADDR <= efap_pkg::CPU_BIG_HI) begin
            cdec.ok  = 1'b1;
            cdec.row = {1'b0, coff[20:3]};
            cdec.hw  = CPU_ADDR[2:1];
        // small sectors paired in 16 KB ranges
        end else if (CPU_ADDR[31:16] == efap_pkg::CPU_SMALL_SEG) begin
            cdec.ok  = 1'b1;
            cdec.row = efap_pkg::SMALL_ROW_BASE | {6'h00, CPU_ADDR[15:3]};
            cdec.hw  = CPU_ADDR[2:1];
        end
    end
    // programmer address decode, one contiguous range per sector
    always_comb begin
        pdec = '0;
        // big sector number from address bits 20..16
        if (PROGRAMMING_ADDRESS[efap_pkg::PRG_BIG_BIT]) begin
            pdec.ok  = 1'b1;
            pdec.row = {1'b0, PROGRAMMING_ADDRESS[20:17], PROGRAMMING_ADDRESS[15:2]};
            pdec.hw  = {PROGRAMMING_ADDRESS[16], PROGRAMMING_ADDRESS[1]};
        // small sector number from address bits 15..13
        end else if (PROGRAMMING_ADDRESS[21:16] == efap_pkg::PRG_SMALL_SEG) begin
            pdec.ok  = 1'b1;
            pdec.row = efap_pkg::SMALL_ROW_BASE
                     | {6'h00, PROGRAMMING_ADDRESS[15:14], PROGRAMMING_ADDRESS[12:2]};
            pdec.hw  = {PROGRAMMING_ADDRESS[13], PROGRAMMING_ADDRESS[1]};
        end
        // bit 0 low and bit 22 high, else refused
        if (PROGRAMMING_ADDRESS[0] || !PROGRAMMING_ADDRESS[efap_pkg::PRG_HIGH_BIT]) begin
            pdec.ok = 1'b0;
        end
    end
    // cpu alignment and mode-based refusal
    always_comb begin
        cpu_align  = (mode == efap_pkg::MODE_W16) ? !CPU_ADDR[0] : (CPU_ADDR[1:0] == 2'b00);
        // no fetch from flash in halfword mode
        cpu_refuse = !cdec.ok || !cpu_align || (CPU_FETCH && mode == efap_pkg::MODE_W16);
        // halfword at +0 from bits 31..16, at +2 from 15..0
        whalf      = CPU_ADDR[1] ? CPU_WDATA[15:0] : CPU_WDATA[31:16];
    end
    // access sequencer next state
    always_comb begin
        next_state     = state;
        next_src       = src;
        next_mode      = mode;
        next_pend      = pend;
        next_pend_mode = pend_mode;
        next_wcnt      = wcnt;
        next_we        = we;
        next_err       = err;
        next_row       = row;
        next_hw        = hw;
        next_wdata     = wdata;
        next_rdata     = rdata;
        next_pdata     = pdata;
        next_secured   = secured;
        next_lbuf      = lbuf;
        next_lrow      = lrow;
        next_lvalid    = lvalid;
        next_pvalid    = pvalid && !PROG_OE_N && !PROG_CE_N;
        next_ce_q      = PROG_CE_N;
        case (state)
            ST_BOOT: begin
                // fetch the security vector row first
                next_src   = efap_pkg::SRC_BOOT;
                next_we    = 1'b0;
                next_row   = efap_pkg::SEC_ROW;
                next_hw    = 2'b00;
                next_wcnt  = WAIT_STATES;
                next_state = ST_ACCESS;
            end
            ST_IDLE: begin
                next_err = 1'b0;
                // pending mode applied only between accesses
                if (pend) begin
                    next_mode   = pend_mode;
                    next_pend   = 1'b0;
                    next_lvalid = 1'b0;
                end else if (prog_start) begin
                    next_src   = efap_pkg::SRC_PROG;
                    next_we    = !PROG_WE_N;
                    next_row   = pdec.row;
                    next_hw    = pdec.hw;
                    // one halfword on the data lines
                    next_wdata = {4{PROG_DQ_I}};
                    next_wcnt  = WAIT_STATES;
                    next_lvalid = 1'b0;
                    if (!pdec.ok || secured) begin
                        next_err   = 1'b1;
                        next_pdata = 16'h0000;
                        next_state = ST_DONE;
                    end else begin
                        next_state = ST_ACCESS;
                    end
                end else if (CPU_REQ && !prog_mode) begin
                    next_src   = efap_pkg::SRC_CPU;
                    next_we    = CPU_WE;
                    next_row   = cdec.row;
                    next_hw    = CPU_ADDR[2:1];
                    next_wcnt  = WAIT_STATES;
                    // word written to the lane at +0 or +4, halfword copied to all four lanes in 16-bit mode
                    next_wdata = (mode == efap_pkg::MODE_W16) ? {4{whalf}} : {2{CPU_WDATA}};
                    if (cpu_refuse) begin
                        next_err   = 1'b1;
                        next_state = ST_DONE;
                    // writes in 64-bit mode end without effect
                    end else if (CPU_WE && mode == efap_pkg::MODE_W64) begin
                        next_state = ST_DONE;
                    // second word of a fetched row needs no access
                    end else if (!CPU_WE && mode == efap_pkg::MODE_W64 && lvalid
                                 && lrow == cdec.row) begin
                        next_rdata = CPU_ADDR[2] ? lbuf[31:0] : lbuf[63:32];
                        next_state = ST_DONE;
                    end else begin
                        if (CPU_WE) begin
                            next_lvalid = 1'b0;
                        end
                        next_state = ST_ACCESS;
                    end
                end
            end
            ST_ACCESS: begin
                // access lasts the programmed wait states plus one
                if (wcnt == 4'h0) begin
                    next_state = ST_DONE;
                    if (src == efap_pkg::SRC_BOOT) begin
                        next_secured = (ARR_RDATA[63:32] == efap_pkg::SEC_KEY);
                        next_state   = ST_IDLE;
                    end else if (src == efap_pkg::SRC_PROG) begin
                        next_pdata  = ARR_RDATA[63 - 16 * hw -: 16];
                        next_pvalid = !we;
                    end else if (mode == efap_pkg::MODE_W64) begin
                        next_lbuf   = ARR_RDATA;
                        next_lrow   = row;
                        next_lvalid = 1'b1;
                        next_rdata  = hw[1] ? ARR_RDATA[31:0] : ARR_RDATA[63:32];
                    end else if (mode == efap_pkg::MODE_W32) begin
                        next_rdata = hw[1] ? ARR_RDATA[31:0] : ARR_RDATA[63:32];
                    end else begin
                        // halfword returned on its own byte lanes
                        next_rdata = hw[0] ? {16'h0000, ARR_RDATA[63 - 16 * hw -: 16]}
                                           : {ARR_RDATA[63 - 16 * hw -: 16], 16'h0000};
                    end
                end else begin
                    next_wcnt = wcnt - 4'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // boot routine entry only; a new request beats the clear
        if (MODE_REQ && MODE_REQ_PC == efap_pkg::MODE_SW_ENTRY
            && MODE_REQ_SEL != 2'b11) begin
            next_pend      = 1'b1;
            next_pend_mode = efap_pkg::efap_mode_t'(MODE_REQ_SEL);
        end
    end

    // sequencer registers
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state     <= ST_BOOT;
            src       <= efap_pkg::SRC_BOOT;
            mode      <= efap_pkg::efap_mode_t'(efap_pkg::MODE_RESET);
            pend      <= 1'b0;
            pend_mode <= efap_pkg::efap_mode_t'(efap_pkg::MODE_RESET);
            wcnt      <= 4'h0;
            we        <= 1'b0;
            err       <= 1'b0;
            row       <= 19'h0_0000;
            hw        <= 2'b00;
            wdata     <= 64'h0;
            rdata     <= 32'h0;
            pdata     <= 16'h0;
            secured   <= 1'b0;
            lbuf      <= 64'h0;
            lrow      <= 19'h0_0000;
            lvalid    <= 1'b0;
            ce_q      <= 1'b1;
            pvalid    <= 1'b0;
        end else begin
            state     <= next_state;
            src       <= next_src;
            mode      <= next_mode;
            pend      <= next_pend;
            pend_mode <= next_pend_mode;
            wcnt      <= next_wcnt;
            we        <= next_we;
            err       <= next_err;
            row       <= next_row;
            hw        <= next_hw;
            wdata     <= next_wdata;
            rdata     <= next_rdata;
            pdata     <= next_pdata;
            secured   <= next_secured;
            lbuf      <= next_lbuf;
            lrow      <= next_lrow;
            lvalid    <= next_lvalid;
            ce_q      <= next_ce_q;
            pvalid    <= next_pvalid;
        end
    end

    // array command and port outputs
    always_comb begin
        ARR_CMD.req   = (state == ST_ACCESS);
        ARR_CMD.we    = we && (state == ST_ACCESS);
        ARR_CMD.row   = row;
        // array width follows the access mode for cpu accesses, halfword for boot and programmer
        ARR_CMD.width = (src == efap_pkg::SRC_CPU) ? mode : efap_pkg::MODE_W16;
        ARR_CMD.hw    = hw;
        ARR_CMD.wdata = wdata;
        CPU_READY     = (state == ST_DONE) && (src == efap_pkg::SRC_CPU);
        CPU_ERR       = CPU_READY && err;
        CPU_RDATA     = rdata;
        PROG_DQ_O     = pdata;
        PROG_DQ_OE_N  = !(pvalid && !PROG_OE_N);
        PROG_MODE     = prog_mode;
        SECURED       = secured;
        ACCESS_MODE   = mode;
    end

    // last row of the array is the capacity limit
    array_size_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ARR_CMD.req |-> (ARR_CMD.row < 19'(efap_pkg::ARRAY_BYTES / 8)))
        else $error("array row beyond capacity");
    wait_len_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state == ST_IDLE ##1 state == ST_ACCESS && wcnt == 4'h3) |-> ##1 state == ST_ACCESS [*3]
        ##1 state != ST_ACCESS)
        else $error("access length not wait states plus one");
    sec_row_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state == ST_ACCESS && src == efap_pkg::SRC_BOOT) |-> ARR_CMD.row == efap_pkg::SEC_ROW)
        else $error("security read at wrong row");
    no_write64_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        ARR_CMD.we |-> !(src == efap_pkg::SRC_CPU && mode == efap_pkg::MODE_W64))
        else $error("array written in 64-bit mode");
    no_fetch16_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state == ST_IDLE && !pend && !prog_mode && CPU_REQ && CPU_FETCH
         && mode == efap_pkg::MODE_W16) |-> ##1 (CPU_READY && CPU_ERR))
        else $error("fetch accepted in 16-bit mode");
    mode_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        $changed(mode) |-> $past(state) == ST_IDLE)
        else $error("mode changed during access");
    prog_only_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        CPU_READY |-> !$past(prog_mode, 2) || err || $past(state, 2) != ST_IDLE)
        else $error("cpu served in programming mode");
    prog_bit0_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (state == ST_IDLE && !pend && prog_start && PROGRAMMING_ADDRESS[0])
        |-> ##1 (state == ST_DONE && err))
        else $error("odd programmer address accepted");
    cpu_read_c:  cover property (@(posedge CLK_SYS) CPU_READY && !CPU_ERR && !we);
    prog_read_c: cover property (@(posedge CLK_SYS) !PROG_DQ_OE_N);
    mode_sw_c:   cover property (@(posedge CLK_SYS) $changed(mode));

endmodule : efap_top

// File: tb/efap_arr_model.sv
// flash array model behind the access path
`timescale 1ns/10ps
module efap_arr_model (
    input  wire logic                CLK_SYS, // system clock
    input  wire efap_pkg::efap_arr_t CMD,     // row command
    input  wire logic                LOCK,    // vector holds key
    output logic [63:0]              RDATA    // row contents
);
    logic [63:0] last = 64'h0;
    logic [63:0] row_q;
    // row pattern, key in vector row
    always_comb begin
        row_q = {CMD.row, 13'h1a5, ~CMD.row, 13'h0c3};
        if (LOCK && CMD.row == efap_pkg::SEC_ROW)
            row_q = {efap_pkg::SEC_KEY, 32'h0};
        RDATA = CMD.req ? row_q : ~last;
    end
    // idle bus shows the inverse of the last row
    always_ff @(posedge CLK_SYS)
        if (CMD.req)
            last <= row_q;
endmodule : efap_arr_model

// File: tb/tb_top.sv
// self-checking bench for the flash access path
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, rst = 1, mreq = 0, creq = 0, cwe = 0, cf = 0;
    logic ce_n = 1, we_n = 1, oe_n = 1, lock = 0;
    logic rdy, err, dqoe_n, pmode, sec, g_req, g_drv, g_err;
    logic [2:0] pins = 3'h0;
    logic [3:0] ws = 4'h0;
    logic [1:0] msel = 2'h0, mode, g_mode;
    logic [15:0] mpc = 16'h0, dqi = 16'h0, dqo, g_dq;
    logic [31:0] ca = 32'h0, cwd = 32'h0, rd, g_rd;
    logic [22:0] fa = 23'h0;
    logic [63:0] ard;
    efap_pkg::efap_arr_t cmd, l_cmd;
    int fail_count = 0, comparisons = 0, lat;

    efap_top u_dut (.CLK_SYS(clk), .RST(rst), .MODE_SELECT_PINS(pins), .WAIT_STATES(ws),
        .MODE_REQ(mreq), .MODE_REQ_SEL(msel), .MODE_REQ_PC(mpc), .CPU_REQ(creq),
        .CPU_WE(cwe), .CPU_FETCH(cf), .CPU_ADDR(ca), .CPU_WDATA(cwd), .CPU_READY(rdy),
        .CPU_ERR(err), .CPU_RDATA(rd), .PROGRAMMING_ADDRESS(fa), .PROG_CE_N(ce_n),
        .PROG_WE_N(we_n), .PROG_OE_N(oe_n), .PROG_DQ_I(dqi), .PROG_DQ_O(dqo),
        .PROG_DQ_OE_N(dqoe_n), .PROG_MODE(pmode), .SECURED(sec), .ACCESS_MODE(mode),
        .ARR_CMD(cmd), .ARR_RDATA(ard));
    efap_arr_model u_arr (.CLK_SYS(clk), .CMD(cmd), .LOCK(lock), .RDATA(ard));

    // clock at 20 MHz
    initial forever #25 clk = ~clk;

    function automatic logic [15:0] hw(input logic [18:0] r, input int i);
        logic [63:0] v;
        v = {r, 13'h1a5, ~r, 13'h0c3};
        return v[63-16*i -: 16];
    endfunction

    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic cpu(input logic [31:0] a, input logic w, f, input logic [31:0] d);
        lat = 0;
        g_req = 0;
        @(negedge clk);
        {ca, cwe, cf, cwd, creq} = {a, w, f, d, 1'b1};
        do begin
            @(negedge clk);
            lat++;
            if (cmd.req === 1'b1) begin
                g_req = 1;
                l_cmd = cmd;
            end
        end while (rdy !== 1'b1 && lat < 30);
        {g_err, g_rd, g_mode} = {err, rd, mode};
        {creq, cwe, cf} = 3'h0;
    endtask

    task automatic msw(input logic [1:0] m, input logic [15:0] pc);
        @(negedge clk);
        {mreq, msel, mpc} = {1'b1, m, pc};
        @(negedge clk);
        mreq = 0;
        repeat (3) @(negedge clk);
    endtask

    // programmer keeps bit0 low, bit22 high unless refused on purpose
    task automatic prog(input logic [22:0] a, input logic w, input logic [15:0] d);
        {g_req, g_drv} = 2'b00;
        @(negedge clk);
        {fa, dqi, ce_n, we_n, oe_n} = {a, d, 1'b0, !w, w};
        repeat (10) begin
            @(negedge clk);
            if (cmd.req === 1'b1) begin
                g_req = 1;
                l_cmd = cmd;
            end
            if (dqoe_n === 1'b0 && !g_drv) begin
                g_drv = 1;
                g_dq = dqo;
            end
        end
        {ce_n, we_n, oe_n} = 3'h7;
        @(negedge clk);
    endtask

    task automatic do_reset;
        rst = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (8) @(negedge clk);
    endtask

    task automatic t_cpu32;
        chk(mode === efap_pkg::MODE_RESET && sec === 1'b0 && dqoe_n === 1'b1, "reset");
        cpu(32'h40000, 0, 0, 0);
        chk(lat == 2 && l_cmd.width === efap_pkg::MODE_W32, "word access");
        chk(g_rd === {hw(0, 0), hw(0, 1)}, "big even lane");
        cpu(32'h23fffc, 0, 0, 0);
        chk(g_rd === {hw(19'h3ffff, 2), hw(19'h3ffff, 3)}, "big top");
        cpu(32'h240008, 0, 0, 0);
        chk(g_rd === {hw(19'h40001, 0), hw(19'h40001, 1)}, "small lane");
        cpu(32'h24fffc, 0, 0, 0);
        chk(g_rd === {hw(19'h41fff, 2), hw(19'h41fff, 3)}, "last row");
        cpu(32'h250000, 0, 0, 0);
        chk(g_err === 1'b1 && lat == 1, "above array");
        cpu(32'h3fffc, 0, 0, 0);
        chk(g_err === 1'b1, "below array");
        ws = 4'h3;
        cpu(32'h40010, 0, 0, 0);
        chk(lat == 5, "wait states");
        cpu(32'h40004, 1, 0, 32'h12345678);
        chk(l_cmd.we === 1'b1 && l_cmd.wdata[31:0] === 32'h12345678, "word write");
        $display("test cpu32 done");
    endtask

    task automatic t_modes;
        msw(efap_pkg::MODE_W16, 16'h1234);
        chk(mode === efap_pkg::MODE_W32, "wrong entry");
        fork
            cpu(32'h40000, 0, 0, 0);
            begin
                @(negedge clk);
                msw(efap_pkg::MODE_W16, efap_pkg::MODE_SW_ENTRY);
            end
        join
        // pending switch lands one idle edge after the access ends
        repeat (2) @(negedge clk);
        chk(g_mode === efap_pkg::MODE_W32, "switch mid access");
        chk(mode === efap_pkg::MODE_W16, "switch done");
        ws = 4'h0;
        cpu(32'h40000, 0, 1, 0);
        chk(g_err === 1'b1, "fetch in halfword mode");
        cpu(32'h40002, 0, 0, 0);
        chk(g_rd === {16'h0, hw(0, 1)} && l_cmd.width === efap_pkg::MODE_W16, "hw rd");
        cpu(32'h40000, 1, 0, 32'habcd1234);
        chk(l_cmd.hw === 2'h0 && l_cmd.wdata[63:48] === 16'habcd, "hw +0");
        cpu(32'h40002, 1, 0, 32'habcd1234);
        chk(l_cmd.hw === 2'h1 && l_cmd.wdata[47:32] === 16'h1234, "hw +2");
        msw(efap_pkg::MODE_W64, efap_pkg::MODE_SW_ENTRY);
        cpu(32'h40000, 1, 0, 32'h1);
        chk(g_err === 1'b0 && g_req === 1'b0, "no write in dword mode");
        cpu(32'h40008, 0, 1, 0);
        chk(g_err === 1'b0 && lat == 2 && g_rd === {hw(1, 0), hw(1, 1)}, "fetch");
        cpu(32'h4000c, 0, 0, 0);
        chk(g_req === 1'b0 && lat == 1 && g_rd === {hw(1, 2), hw(1, 3)}, "pair");
        $display("test modes done");
    endtask

    task automatic t_prog;
        pins = efap_pkg::PROG_PINS;
        @(negedge clk);
        chk(pmode === 1'b1, "programming mode");
        // cpu requests get no answer while the programmer owns the array
        cpu(32'h40000, 0, 0, 0);
        chk(lat == 30 && g_req === 1'b0, "cpu ignored");
        prog(23'h600002, 0, 0);
        chk(g_drv === 1'b1 && g_dq === hw(0, 1), "big sector");
        prog(23'h610000, 0, 0);
        chk(g_dq === hw(0, 2), "odd big sector");
        prog(23'h5f2000, 0, 0);
        chk(g_dq === hw(19'h40000, 2), "small sector");
        prog(23'h200000, 0, 0);
        chk(g_drv === 1'b0 && g_req === 1'b0, "bit22 low");
        prog(23'h600001, 0, 0);
        chk(g_drv === 1'b0 && g_req === 1'b0, "bit0 high");
        prog(23'h600004, 1, 16'h5a5a);
        chk(l_cmd.row === 19'h1 && l_cmd.wdata[63:48] === 16'h5a5a, "prog write");
        lock = 1;
        do_reset();
        chk(sec === 1'b1, "locked");
        prog(23'h600000, 0, 0);
        chk(g_drv === 1'b0 && g_req === 1'b0, "locked refuse");
        $display("test prog done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles of the tests
    initial begin
        #250000;
        fail_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        do_reset();
        t_cpu32();
        t_modes();
        t_prog();
        print_verdict();
    end
endmodule : tb_top
